// [ahrp_cfg.svh]
`ifndef AHRP_CFG_SVH
`define AHRP_CFG_SVH
`define AHRP_DATA_W        8
`define AHRP_ADDR_W        9
`define AHRP_CLK_PERIOD_PS 5000
`define AHRP_RST_MIN_PS    100000
`define AHRP_RST_MIN_CYC   ((`AHRP_RST_MIN_PS + `AHRP_CLK_PERIOD_PS - 1) / `AHRP_CLK_PERIOD_PS)
`define AHRP_REG_RST       8'h00
`define AHRP_NUM_REGS      512
`define AHRP_NUM_IRQ       8
`endif

// [ahrp_pkg.sv]
`include "ahrp_cfg.svh"
package ahrp_pkg;
	typedef enum logic [2:0] {
		AHRP_IDLE  = 3'b001,
		AHRP_READ  = 3'b010,
		AHRP_WRITE = 3'b100
	} ahrp_state_t;
	typedef logic [`AHRP_DATA_W-1:0] ahrp_data_t;
	typedef logic [`AHRP_ADDR_W-1:0] ahrp_addr_t;
endpackage

// [ahrp_addr_latch.sv]
`timescale 1ns/1ps
`include "ahrp_cfg.svh"
module ahrp_addr_latch #(
	parameter int ADDR_W = `AHRP_ADDR_W
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              latch_enable,
	input  wire logic [ADDR_W-1:0] addr_in,
	output logic      [ADDR_W-1:0] addr_out
);
	logic [ADDR_W-1:0] held_ff;

	// clocked hold register; transparency done combinationally
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			held_ff <= '0;
		end else if (latch_enable) begin
			held_ff <= addr_in;
		end
	end

	assign addr_out = latch_enable ? addr_in : held_ff;
endmodule

// [ahrp_top.sv]
`timescale 1ns/1ps
`include "ahrp_cfg.svh"
// How it works
// - reads and writes are accepted only while chip_select_n is low.
// - with read strobe and chip select both low, the bus carries the addressed register.
// - on the rising write strobe with chip select low, bus data goes to the addressed register.
// - the address latch is transparent while latch enable is high and holds while low.
// - the nine-bit latched address selects the register accessed.
// - a low device_reset_n resets the whole block at once, without a clock.
// - the interrupt output is pulled low when any unmasked source has an event.
// - the interrupt output stays low until every unmasked source is acknowledged.
module ahrp_top #(
	parameter int ADDR_W  = `AHRP_ADDR_W,
	parameter int DATA_W  = `AHRP_DATA_W,
	parameter int NUM_IRQ = `AHRP_NUM_IRQ
) (
	input  wire logic               clk,
	input  wire logic               sys_rst,
	input  wire logic               device_reset_n,
	input  wire logic               chip_select_n,
	input  wire logic               read_strobe_n,
	input  wire logic               write_strobe_n,
	input  wire logic               addr_latch_enable,
	input  wire logic [ADDR_W-1:0]  addr,
	input  wire logic [DATA_W-1:0]  data_in,
	output logic      [DATA_W-1:0]  data_out,
	output logic                    data_oe,
	input  wire logic [NUM_IRQ-1:0] irq_event,
	input  wire logic [NUM_IRQ-1:0] irq_mask,
	input  wire logic [NUM_IRQ-1:0] irq_ack,
	output logic                    irq_open_drain_n_oe,
	output logic                    irq_open_drain_n_out,
	output logic                    test_mode
);
	localparam int NREG = 1 << ADDR_W;

	logic                     rst;
	logic [ADDR_W-1:0]        cur_addr;
	logic [DATA_W-1:0]        regs_ff [NREG];
	logic                     wr_prev_ff;
	logic                     wr_rise;
	logic                     wr_commit;
	logic                     rd_active;
	logic [NUM_IRQ-1:0]       pend_ff;
	logic [NUM_IRQ-1:0]       nxt_pend;
	logic [DATA_W-1:0]        data_out_ff;
	logic [DATA_W-1:0]        nxt_data_out;
	logic                     data_oe_ff;
	logic                     irq_oe_ff;
	logic                     irq_out_ff;
	logic                     test_mode_ff;
	logic [DATA_W-1:0]        wr_data_ff;
	ahrp_pkg::ahrp_state_t    state_ff;
	ahrp_pkg::ahrp_state_t    nxt_state;

	// either reset acts immediately: clears everything but test mode and wr_prev_ff, which it sets, and state_ff, which goes to one-hot idle
	assign rst = sys_rst | ~device_reset_n;

	ahrp_addr_latch #(
		.ADDR_W(ADDR_W)
	) u_latch (
		.clk          (clk),
		.rst          (rst),
		.latch_enable (addr_latch_enable),
		.addr_in      (addr),
		.addr_out     (cur_addr)
	);

	// a strobe only counts while chip select is low; shared by read and write decodes
	function automatic logic strobe_hit(input logic cs_n, input logic strobe_n);
		return ~cs_n & ~strobe_n;
	endfunction

	assign rd_active = strobe_hit(chip_select_n, read_strobe_n);
	assign wr_rise   = ~wr_prev_ff & write_strobe_n;
	// a bare rising strobe is not enough: the low phase must have been seen selected
	assign wr_commit = wr_rise & (state_ff == ahrp_pkg::AHRP_WRITE) & ~chip_select_n;

	always_comb begin
		nxt_state = ahrp_pkg::AHRP_IDLE;
		unique case (state_ff)
			ahrp_pkg::AHRP_IDLE: begin
				if (rd_active) begin
					nxt_state = ahrp_pkg::AHRP_READ;
				end else if (strobe_hit(chip_select_n, write_strobe_n)) begin
					nxt_state = ahrp_pkg::AHRP_WRITE;
				end
			end
			ahrp_pkg::AHRP_READ: begin
				if (rd_active) begin
					nxt_state = ahrp_pkg::AHRP_READ;
				end
			end
			ahrp_pkg::AHRP_WRITE: begin
				// chip select dropping mid-write aborts it
				if (strobe_hit(chip_select_n, write_strobe_n)) begin
					nxt_state = ahrp_pkg::AHRP_WRITE;
				end
			end
			// a corrupted one-hot code falls back to idle
			default: begin
				nxt_state = ahrp_pkg::AHRP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= ahrp_pkg::AHRP_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// resets to the idle pin level, so no false rising edge follows reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_prev_ff <= 1'b1;
		end else begin
			wr_prev_ff <= write_strobe_n;
		end
	end

	// data sampled while strobe is low, so the rising edge uses stable data
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_data_ff <= `AHRP_REG_RST;
		end else if (~write_strobe_n) begin
			wr_data_ff <= data_in;
		end
	end

	// whole file clears on either reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NREG; i++) begin
				regs_ff[i] <= `AHRP_REG_RST;
			end
		end else if (wr_commit) begin
			regs_ff[cur_addr] <= wr_data_ff;
		end
	end

	// drivers follow the strobe one cycle later, never outside a read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			data_oe_ff <= 1'b0;
		end else begin
			data_oe_ff <= rd_active;
		end
	end

	// idle value is zero so a stray enable never leaks register contents
	always_comb begin
		nxt_data_out = `AHRP_REG_RST;
		if (rd_active) begin
			nxt_data_out = regs_ff[cur_addr];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			data_out_ff <= `AHRP_REG_RST;
		end else begin
			data_out_ff <= nxt_data_out;
		end
	end

	// test mode set by reset, cleared by the first chip select high
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			test_mode_ff <= 1'b1;
		end else if (chip_select_n) begin
			test_mode_ff <= 1'b0;
		end
	end

	// set wins over acknowledge in the same cycle, so no event is lost
	assign nxt_pend = (pend_ff & ~irq_ack) | irq_event;

	// one pending flag per source
	for (genvar g = 0; g < NUM_IRQ; g++) begin : g_src
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				pend_ff[g] <= 1'b0;
			end else begin
				pend_ff[g] <= nxt_pend[g];
			end
		end
	end

	// masked sources still pend, so unmasking later pulls the line low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_oe_ff <= 1'b0;
		end else begin
			irq_oe_ff <= |(nxt_pend & ~irq_mask);
		end
	end

	// open drain: the level is always low, only the enable moves
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_out_ff <= 1'b0;
		end else begin
			irq_out_ff <= 1'b0;
		end
	end

	assign data_out             = data_out_ff;
	assign data_oe              = data_oe_ff;
	assign irq_open_drain_n_oe  = irq_oe_ff;
	assign irq_open_drain_n_out = irq_out_ff;
	assign test_mode            = test_mode_ff;
endmodule

// [ahrp_checker.sv]
`timescale 1ns/1ps
module ahrp_checker (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       device_reset_n,
	input wire logic       chip_select_n,
	input wire logic       read_strobe_n,
	input wire logic [7:0] irq_event,
	input wire logic [7:0] irq_mask,
	input wire logic [7:0] irq_ack,
	input wire logic [7:0] data_out,
	input wire logic       data_oe,
	input wire logic       irq_open_drain_n_oe,
	input wire logic       irq_open_drain_n_out,
	input wire logic       test_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst || !device_reset_n);
	sequence rd_s;
		!chip_select_n && !read_strobe_n;
	endsequence
	rd_drive_a: assert property (rd_s |=> data_oe) else $error("read not driven");
	cs_gate_a: assert property (chip_select_n |=> !data_oe) else $error("unselected drive");
	bus_idle_a: assert property (read_strobe_n |=> !data_oe) else $error("idle drive");
	idle_zero_a: assert property (!data_oe |-> data_out == 8'h00) else $error("data not 0");
	irq_set_a: assert property (|(irq_event & ~irq_mask) |=> irq_open_drain_n_oe)
		else $error("irq missed");
	irq_hold_a: assert property (irq_open_drain_n_oe && irq_ack == 8'h00 && $stable(irq_mask)
		|=> irq_open_drain_n_oe) else $error("irq dropped");
	irq_od_a: assert property (irq_open_drain_n_out == 1'b0) else $error("od level");
	test_clr_a: assert property (chip_select_n |=> !test_mode) else $error("test mode");
	rst_out_a: assert property (disable iff (1'b0) !device_reset_n |-> !data_oe && test_mode)
		else $error("reset state");
endmodule
bind ahrp_top ahrp_checker chk_u (.clk, .sys_rst, .device_reset_n, .chip_select_n,
	.read_strobe_n, .irq_event, .irq_mask, .irq_ack, .data_out, .data_oe,
	.irq_open_drain_n_oe, .irq_open_drain_n_out, .test_mode);

// [ahrp_host_model.sv]
`timescale 1ns/1ps
module ahrp_host_model (
	input wire logic clk,
	output logic       chip_select_n = 1'b1,
	output logic       read_strobe_n = 1'b1,
	output logic       write_strobe_n = 1'b1,
	output logic       addr_latch_enable = 1'b1,
	output logic [8:0] addr = 9'h000,
	output logic [7:0] data_in = 8'h00
);
	task automatic acc(input logic w, s, input logic [8:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		chip_select_n = s;
		addr = a;
		data_in = d;
		read_strobe_n = w;
		write_strobe_n = !w;
		repeat (2) @(posedge clk);
		#1 read_strobe_n = 1'b1;
		write_strobe_n = 1'b1;
		@(posedge clk) #1;
		chip_select_n = 1'b1;
		data_in = ~d; // released bus must not keep the old value
		@(posedge clk);
	endtask
endmodule

// [async_host_register_port_tb.sv]
`timescale 1ns/1ps
`include "ahrp_cfg.svh"
module async_host_register_port_tb;
	logic clk = 0, sys_rst = 1, device_reset_n = 1, oe_d = 0;
	logic [7:0] irq_event = 0, irq_mask = 0, irq_ack = 0, lf = 8'h59, data_in, data_out;
	logic [8:0] addr, a;
	logic chip_select_n, read_strobe_n, write_strobe_n, addr_latch_enable, data_oe;
	logic irq_open_drain_n_oe, irq_open_drain_n_out, test_mode;
	int fail_count = 0, num_checks = 0;
	logic [7:0] exq[$];
	initial forever #2.5 clk = ~clk;
	ahrp_host_model host (.clk, .chip_select_n, .read_strobe_n, .write_strobe_n,
		.addr_latch_enable, .addr, .data_in);
	ahrp_top dut_u (.clk, .sys_rst, .device_reset_n, .chip_select_n, .read_strobe_n,
		.write_strobe_n, .addr_latch_enable, .addr, .data_in, .data_out, .data_oe, .irq_event,
		.irq_mask, .irq_ack, .irq_open_drain_n_oe, .irq_open_drain_n_out, .test_mode);
	task chk(input string n, input logic [7:0] s, e);
		num_checks++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task rd(input logic [8:0] ra, input logic [7:0] e);
		exq.push_back(e);
		host.acc(1'b0, 1'b0, ra, 8'h00);
	endtask
	task step;
		@(posedge clk) #1;
	endtask
	always @(negedge clk) begin
		if (data_oe && !oe_d) begin
			chk("rd_note", 8'(exq.size() != 0), 8'h01);
			if (exq.size() != 0) chk("read", data_out, exq.pop_front());
		end
		oe_d = data_oe;
	end
	initial begin
		repeat (40000) @(posedge clk);
		fail_count++;
		tally_and_finish;
	end
	initial begin
		repeat (20) @(posedge clk);
		#1 sys_rst = 0;
		chk("tmode", {7'h0, test_mode}, 8'h01);
		repeat (2) step;
		chk("tmode", {7'h0, test_mode}, 8'h00);
		host.addr = 9'h0A5;
		step;
		host.addr_latch_enable = 0;
		host.acc(1'b1, 1'b0, 9'h05A, 8'hC3);
		#1 host.addr_latch_enable = 1;
		rd(9'h0A5, 8'hC3);
		rd(9'h05A, 8'h00);
		for (int i = 0; i < 5; i++) begin
			lf = lfsr_next(lf);
			a = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : {lf[0], lf};
			host.acc(1'b1, 1'b0, a, lf);
			rd(a, lf);
		end
		host.acc(1'b1, 1'b1, a, ~lf);
		rd(a, lf);
		host.acc(1'b0, 1'b1, a, 8'h00);
		step;
		irq_mask = 8'h0F;
		irq_event = 8'h01;
		step;
		irq_event = 8'h30;
		step;
		irq_event = 0;
		chk("irq", {7'h0, irq_open_drain_n_oe}, 8'h01);
		repeat (3) step;
		chk("irq", {7'h0, irq_open_drain_n_oe}, 8'h01);
		irq_ack = 8'h10;
		step;
		irq_ack = 0;
		step;
		chk("irq", {7'h0, irq_open_drain_n_oe}, 8'h01);
		irq_ack = 8'h20;
		step;
		irq_ack = 0;
		step;
		chk("irq", {7'h0, irq_open_drain_n_oe}, 8'h00);
		irq_event = 8'h40;
		irq_ack = 8'h40;
		step;
		irq_event = 0;
		irq_ack = 0;
		step;
		chk("irq", {7'h0, irq_open_drain_n_oe}, 8'h01);
		irq_ack = 8'h40;
		step;
		irq_ack = 0;
		step;
		chk("irq", {7'h0, irq_open_drain_n_oe}, 8'h00);
		device_reset_n = 0;
		step;
		chk("rst", {6'h0, test_mode, data_oe}, 8'h02);
		repeat (`AHRP_RST_MIN_CYC) step;
		device_reset_n = 1;
		rd(a, 8'h00);
		host.acc(1'b1, ~device_reset_n, a, lf);
		rd(a, lf);
		chk("pend", 8'(exq.size()), 8'h00);
		tally_and_finish;
	end
endmodule
